//--- logic/alpo_output_stage.v
/*
 * alpo_output_stage.v: formats converter samples onto DDR output lanes with a
 * forwarded data clock, range flag, mode, format, phase, drive, power-down.
 * Assumes: sampleStrobe marks one converter sample per pulse in core_clk;
 * the link clock pin is sampled by core_clk and its edges mark DDR slots.
 */
`include "alpo_defines.vh"
`default_nettype none

// Notes on behaviour
// R1 - drive current reducible via drive register
// R2 - offset binary, twos complement, gray formats
// R3 - outputs high impedance in power-down; code drops laneOe for the lanes only, strobeOut and rangeOut stay driven
// R4 - samples appear 33 sample cycles later
// R5 - data clock phase in 90 degree steps
// R6 - new data on each clock edge
// R7 - range flag delayed 33 cycles too
// R8 - mode 0: fourteen parallel lanes, one converter
// R9 - mode 1: two converters interleaved, twice rate
// R10 - mode 2: channel A pair lanes only
// R11 - mode 3: both channel pair lane groups
// R12 - pair lanes carry bit pairs 13/12 down
// R13 - mode 4: one 16-bit converter on bytes
// R14 - mode 5: two converters, four times rate
// R15 - mode 6: four converters, eight times rate
// R16 - mode 7: eight converters, sixteen times rate
// R17 - output rate is sample rate over decimation
// R18 - lane rate never above 1000 Mbps
// R19 - sample rate kept at least 300 MSPS
// R20 - receiver captures both edges, de-interleaves words
module alpo_output_stage
(
    // clock and reset
    input  wire         core_clk,
    input  wire         sys_rst,
    // register port
    input  wire [11:0]  regAddr,
    input  wire [7:0]   regWrData,
    input  wire         regWrite,
    input  wire         regRead,
    output reg  [7:0]   regRdData,
    // converter samples, eight virtual words of 16 bits
    input  wire         sampleStrobe,
    input  wire [127:0] sampleWords,
    input  wire         rangeIn,
    input  wire [4:0]   chipDecimation,
    // link clock pin, sampled
    input  wire         linkClkPin,
    // output pins
    output reg  [13:0]  laneOut,
    output reg          laneOe,
    output reg          strobeOut,
    output reg          rangeOut,
    output reg  [2:0]   driveLevel,
    output reg          rateError
);

    reg  [7:0]   modeReg;
    reg  [7:0]   phaseReg;
    reg  [7:0]   driveReg;
    reg  [7:0]   formatReg;
    reg  [7:0]   powerReg;
    reg          linkSync1;
    reg          linkSync2;
    reg          linkPrev;
    reg  [127:0] delayWords [0:`ALPO_LATENCY-1];
    reg  [`ALPO_LATENCY-1:0] delayRange;
    reg  [127:0] outWords;
    reg          outRange;
    reg  [3:0]   slot;
    reg  [1:0]   phaseCnt;
    reg  [15:0]  selWord;
    reg  [15:0]  chanAWord;
    reg  [15:0]  chanBWord;
    reg  [13:0]  next_laneOut;
    reg          next_rangeOut;
    integer      i;

    wire [2:0] mode = modeReg[`ALPO_MODE_HI:0];
    wire [1:0] fmtSel = formatReg[`ALPO_FMT_HI:0];
    wire linkEdge = linkSync2 ^ linkPrev;
    wire powerDown = powerReg[`ALPO_PWR_BIT];

    function [15:0] fmtWord;
        input [15:0] w;
        input [1:0]  f;
        begin
            if (f == `ALPO_FMT_TWOS)
                fmtWord = {~w[15], w[14:0]};
            else if (f == `ALPO_FMT_GRAY)
                fmtWord = w ^ {1'b0, w[15:1]};
            else
                fmtWord = w;
        end
    endfunction

    // slots per converter sample in each mode
    function [4:0] slotCount;
        input [2:0] m;
        begin
            case (m)
                `ALPO_MODE_PAR1:
                    slotCount = `ALPO_SLOTS_1;
                `ALPO_MODE_BYTE2:
                    slotCount = `ALPO_SLOTS_4;
                `ALPO_MODE_BYTE4:
                    slotCount = `ALPO_SLOTS_8;
                `ALPO_MODE_BYTE8:
                    slotCount = `ALPO_SLOTS_16;
                default:
                    slotCount = `ALPO_SLOTS_2;
            endcase
        end
    endfunction

    // one bit of each adjacent pair, even or odd half
    function [6:0] pairBits;
        input [15:0] w;
        input        odd;
        begin
            if (odd)
                pairBits = {w[15], w[13], w[11], w[9], w[7], w[5], w[3]};
            else
                pairBits = {w[14], w[12], w[10], w[8], w[6], w[4], w[2]};
        end
    endfunction

    // lane rate too high when decimation below slots per sample
    function rateTooHigh;
        input [4:0] dec;
        input [2:0] m;
        begin
            if (dec < slotCount(m))
                rateTooHigh = 1'b1;
            else
                rateTooHigh = 1'b0;
        end
    endfunction

    // register port
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            modeReg   <= `ALPO_RST_MODE;
            phaseReg  <= `ALPO_RST_PHASE;
            driveReg  <= `ALPO_RST_DRIVE;
            formatReg <= `ALPO_RST_FORMAT;
            powerReg  <= `ALPO_RST_POWER;
            regRdData <= 8'h00;
        end
        else
        begin
            if (regWrite)
            begin
                if (regAddr == `ALPO_OFS_MODE)
                    modeReg <= regWrData;
                else if (regAddr == `ALPO_OFS_PHASE)
                    phaseReg <= regWrData;
                else if (regAddr == `ALPO_OFS_DRIVE)
                    driveReg <= regWrData;
                else if (regAddr == `ALPO_OFS_FORMAT)
                    formatReg <= regWrData;
                else if (regAddr == `ALPO_OFS_POWER)
                    powerReg <= regWrData;
            end
            if (regRead)
            begin
                if (regAddr == `ALPO_OFS_MODE)
                    regRdData <= modeReg;
                else if (regAddr == `ALPO_OFS_PHASE)
                    regRdData <= phaseReg;
                else if (regAddr == `ALPO_OFS_DRIVE)
                    regRdData <= driveReg;
                else if (regAddr == `ALPO_OFS_FORMAT)
                    regRdData <= formatReg;
                else if (regAddr == `ALPO_OFS_POWER)
                    regRdData <= {6'h00, rateError, powerDown};
                else
                    regRdData <= 8'h00;
            end
        end
    end

    // link clock synchroniser
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            linkSync1 <= 1'b0;
            linkSync2 <= 1'b0;
            linkPrev  <= 1'b0;
        end
        else
        begin
            linkSync1 <= linkClkPin;
            linkSync2 <= linkSync1;
            linkPrev  <= linkSync2;
        end
    end

    // latency pipeline, one stage per sample
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            delayRange <= {`ALPO_LATENCY{1'b0}};
            outWords   <= 128'h0;
            outRange   <= 1'b0;
        end
        else if (sampleStrobe)
        begin
            delayRange <= {delayRange[`ALPO_LATENCY-2:0], rangeIn}; // R7
            outRange   <= delayRange[`ALPO_LATENCY-1]; // R7
            outWords   <= delayWords[`ALPO_LATENCY-1]; // R4
        end
    end

    always @(posedge core_clk)
    begin
        if (sampleStrobe)
        begin
            delayWords[0] <= sampleWords; // R4
            for (i = 1; i < `ALPO_LATENCY; i = i + 1)
                delayWords[i] <= delayWords[i-1];
        end
    end

    // DDR slot sequencer and forwarded clock
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            slot      <= 4'h0;
            phaseCnt  <= 2'h0;
            strobeOut <= 1'b0;
        end
        else
        begin
            if (sampleStrobe)
            begin
                slot     <= 4'h0;
                phaseCnt <= phaseReg[`ALPO_PHASE_HI:0]; // R5
            end
            else if (linkEdge)
            begin
                // phase counts edges to hold before strobe toggles
                if (phaseCnt != 2'h0)
                    phaseCnt <= phaseCnt - 2'h1; // R5
                else
                    strobeOut <= ~strobeOut; // R6
                if ({1'b0, slot} != slotCount(mode) - 5'h01)
                    slot <= slot + 4'h1; // R6
            end
        end
    end

    // lane contents for the current slot
    always @*
    begin
        selWord       = 16'h0000;
        chanAWord     = fmtWord(outWords[15:0], fmtSel); // R2
        chanBWord     = fmtWord(outWords[31:16], fmtSel); // R2
        next_laneOut  = 14'h0000;
        next_rangeOut = outRange; // R7
        case (mode)
            `ALPO_MODE_PAR1:
            begin
                selWord      = chanAWord;
                next_laneOut = selWord[15:2]; // R8
            end
            `ALPO_MODE_PAR2:
            begin
                // converter follows slot parity
                selWord      = slot[0] ? chanBWord : chanAWord;
                next_laneOut = selWord[15:2]; // R9
            end
            `ALPO_MODE_MUX1:
            begin
                // channel B group left quiet
                next_laneOut = {pairBits(chanAWord, slot[0]), 7'h00}; // R10 R12
            end
            `ALPO_MODE_MUX2:
            begin
                next_laneOut = {pairBits(chanAWord, slot[0]),
                                pairBits(chanBWord, slot[0])}; // R11 R12
            end
            default:
            begin
                // high byte then low byte per converter
                selWord       = fmtWord(outWords[{slot[3:1], 4'h0} +: 16], fmtSel); // R2
                next_laneOut  = {outRange,
                                 (slot[0] ? selWord[7:0] : selWord[15:8]),
                                 5'h00}; // R13 R14 R15 R16
                next_rangeOut = (slot == 4'h0);
            end
        endcase
    end

    // output registers
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            laneOut    <= 14'h0;
            laneOe     <= 1'b0;
            rangeOut   <= 1'b0;
            driveLevel <= 3'h0;
            rateError  <= 1'b0;
        end
        else
        begin
            driveLevel <= driveReg[`ALPO_DRIVE_HI:0]; // R1
            laneOe     <= ~powerDown; // R3
            rateError  <= rateTooHigh(chipDecimation, mode); // R17 R18
            laneOut    <= next_laneOut; // R6
            rangeOut   <= next_rangeOut; // R7
        end
    end

endmodule

`default_nettype wire

//--- pkg/alpo_defines.vh
/*
 * alpo_defines.vh: register offsets, field positions, codes and counts for
 * the converter output stage.
 * Assumes: included by bare name from the design files.
 */
`ifndef ALPO_DEFINES_VH
`define ALPO_DEFINES_VH

// register offsets
`define ALPO_OFS_MODE        12'h568
`define ALPO_OFS_PHASE       12'h569
`define ALPO_OFS_DRIVE       12'h56a
`define ALPO_OFS_FORMAT      12'h561
`define ALPO_OFS_POWER       12'h008

// reset values
`define ALPO_RST_MODE        8'h00
`define ALPO_RST_PHASE       8'h00
`define ALPO_RST_DRIVE       8'h00
`define ALPO_RST_FORMAT      8'h00
`define ALPO_RST_POWER       8'h00

// output mode codes
`define ALPO_MODE_PAR1       3'h0
`define ALPO_MODE_PAR2       3'h1
`define ALPO_MODE_MUX1       3'h2
`define ALPO_MODE_MUX2       3'h3
`define ALPO_MODE_BYTE1      3'h4
`define ALPO_MODE_BYTE2      3'h5
`define ALPO_MODE_BYTE4      3'h6
`define ALPO_MODE_BYTE8      3'h7

// number formats
`define ALPO_FMT_OFFSET      2'h0
`define ALPO_FMT_TWOS        2'h1
`define ALPO_FMT_GRAY        2'h2

// field positions
`define ALPO_MODE_HI         2
`define ALPO_PHASE_HI        1
`define ALPO_DRIVE_HI        2
`define ALPO_FMT_HI          1
`define ALPO_PWR_BIT         0
`define ALPO_DEC_HI          4

// pipeline latency in sample cycles
`define ALPO_LATENCY         33
`define ALPO_LAT_W           6

// output slots per converter sample in each mode
`define ALPO_SLOTS_1         5'h01
`define ALPO_SLOTS_2         5'h02
`define ALPO_SLOTS_4         5'h04
`define ALPO_SLOTS_8         5'h08
`define ALPO_SLOTS_16        5'h10

`endif

//--- testbench/alpo_output_stage_monitor.sv
/* port checker for the output stage
   assumes: bound to alpo_output_stage, core_clk domain only */
`default_nettype none
module alpo_output_stage_monitor (
    input wire logic         core_clk, sys_rst, regWrite, regRead, sampleStrobe,
    input wire logic         rangeIn, linkClkPin, laneOe, strobeOut, rangeOut, rateError,
    input wire logic [11:0]  regAddr,
    input wire logic [7:0]   regWrData, regRdData,
    input wire logic [127:0] sampleWords,
    input wire logic [4:0]   chipDecimation,
    input wire logic [13:0]  laneOut,
    input wire logic [2:0]   driveLevel
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       prevLink;
    logic [4:0] prevDec, calm, quiet;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // cycles without link edge, sample or write; cycles with steady config
    always_ff @(posedge core_clk or posedge sys_rst)
        if (sys_rst)
        begin
            prevLink <= 1'b0;
            prevDec <= 5'h00;
            calm <= 5'h00;
            quiet <= 5'h00;
        end
        else
        begin
            prevLink <= linkClkPin;
            prevDec <= chipDecimation;
            calm <= (linkClkPin != prevLink || sampleStrobe || regWrite) ? 5'h00
                : calm + {4'h0, calm != 5'h1f};
            quiet <= (regWrite || chipDecimation != prevDec) ? 5'h00
                : quiet + {4'h0, quiet != 5'h1f};
        end
    AST_PWR_DN: assert property (regWrite && regAddr == 12'h008 && regWrData[0]
        |-> ##[1:2] !laneOe) else $error("lanes driven in power-down");
    AST_PWR_UP: assert property (regWrite && regAddr == 12'h008 && !regWrData[0]
        |-> ##[1:2] laneOe) else $error("lanes not driven");
    AST_OE_RST: assert property ($fell(sys_rst) |=> laneOe)
        else $error("lanes not driven after reset");
    AST_DRIVE: assert property (regWrite && regAddr == 12'h56a
        |-> ##2 driveLevel == $past(regWrData[2:0], 2)) else $error("drive level wrong");
    AST_RD_UNMAP: assert property (regRead && regAddr == 12'h7ff
        |=> regRdData == 8'h00) else $error("unmapped read not zero");
    AST_RD_HOLD: assert property (!regRead |=> $stable(regRdData))
        else $error("read data moved");
    AST_CALM: assert property (calm > 5'd19 |-> $stable(laneOut) && $stable(strobeOut))
        else $error("output moved without link edge");
    AST_RATE: assert property (quiet > 5'd2 |-> $stable(rateError))
        else $error("rate flag moved");
    cover property (regWrite && regAddr == 12'h008 && regWrData[0]);
    cover property ($rose(rateError));
    cover property ($changed(strobeOut));
endmodule
bind alpo_output_stage alpo_output_stage_monitor alpo_output_stage_monitor_i (.*);
`default_nettype wire

//--- testbench/alpo_link_partner.sv
/* link partner: makes the link clock while run is set, captures lanes
   assumes: strobe and lanes come from the output stage */
`default_nettype none
module alpo_link_partner (
    input  wire logic        run,
    input  wire logic        strobe,
    input  wire logic [13:0] lanes,
    output var  logic        linkClk,
    output var  int          edges
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [13:0] captured;
    initial
    begin
        linkClk = 1'b0;
        edges = 0;
    end
    // clock stands still while run is low
    always #80
        if (run)
            linkClk = ~linkClk;
    always @(strobe)
    begin
        captured = lanes;
        edges++;
    end
endmodule
`default_nettype wire

//--- testbench/test_alpo_output_stage.sv
/* self-checking bench for the output stage
   assumes: link partner model and bound checker */
`default_nettype none
module test_alpo_output_stage;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 0, sys_rst = 1, regWrite = 0, regRead = 0, sampleStrobe = 0;
    logic rangeIn = 0, run = 0, probe = 0, rdPend = 0, prPend = 0;
    logic [11:0]  regAddr = 0;
    logic [7:0]   regWrData = 0, regRdData;
    logic [127:0] sampleWords = 0;
    logic [4:0]   chipDecimation = 5'h01;
    logic [13:0]  laneOut, v, e;
    logic [2:0]   driveLevel;
    logic         laneOe, strobeOut, rangeOut, rateError;
    wire          linkClkPin;
    logic [15:0]  expQ[$];
    int           error_cnt = 0, checked = 0, edges;
    always #10 core_clk = ~core_clk;
    alpo_output_stage alpo_output_stage_i (.*);
    alpo_link_partner alpo_link_partner_i (.run(run), .strobe(strobeOut), .lanes(laneOut),
        .linkClk(linkClkPin), .edges(edges));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("counts: %0d checked, %0d mismatches", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask
    // register read, or lane probe when p is set
    task automatic ask(input bit p, input logic [11:0] a, input logic [15:0] x);
        expQ.push_back(x);
        @(posedge core_clk);
        regRead <= !p;
        probe <= p;
        regAddr <= a;
        @(posedge core_clk);
        regRead <= 1'b0;
        probe <= 1'b0;
    endtask
    task automatic feed(input logic [15:0] w, input logic r);
        repeat (40)
        begin
            @(posedge core_clk);
            sampleStrobe <= 1'b1;
            sampleWords <= {8{w}};
            rangeIn <= r;
            @(posedge core_clk);
            sampleStrobe <= 1'b0;
            repeat (14) @(posedge core_clk);
        end
    endtask
    always @(posedge core_clk)
    begin
        if (rdPend)
            chk({8'h00, regRdData}, expQ.pop_front());
        if (prPend)
            chk({laneOe, rangeOut, laneOut}, expQ.pop_front());
        rdPend <= regRead;
        prPend <= probe;
    end
    initial
    begin
        #300us;
        error_cnt++;
        complete_run();
    end
    initial
    begin
        void'($urandom(32'h1759));
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        ask(0, 12'h568, 16'h0000);
        ask(0, 12'h56a, 16'h0000);
        wr(12'h56a, 8'h05);
        ask(0, 12'h56a, 16'h0005);
        wr(12'h569, 8'h03);
        ask(0, 12'h569, 16'h0003);
        ask(0, 12'h7ff, 16'h0000);
        $display("test registers done");
        wr(12'h568, 8'h07);
        ask(0, 12'h008, 16'h0002);
        wr(12'h568, 8'h00);
        wr(12'h569, 8'h00);
        ask(0, 12'h008, 16'h0000);
        $display("test rate done");
        run <= 1'b1;
        for (int f = 0; f < 3; f++)
        begin
            wr(12'h561, 8'(f));
            v = 14'($urandom());
            e = (f == 0) ? v : (f == 1) ? v ^ 14'h2000 : v ^ (v >> 1);
            feed({v, 2'b00}, f == 1);
            ask(1, 12'h000, {1'b1, f == 1, e});
        end
        chk(16'(edges > 0), 16'h0001);
        run <= 1'b0;
        wr(12'h561, 8'h00);
        wr(12'h568, 8'h03);
        feed({v, 2'b00}, 1'b0);
        e = {2{v[12], v[10], v[8], v[6], v[4], v[2], v[0]}};
        ask(1, 12'h000, {2'b10, e});
        wr(12'h568, 8'h07);
        feed({v, 2'b00}, 1'b0);
        ask(1, 12'h000, {3'b110, v[13:6], 5'h00});
        wr(12'h568, 8'h00);
        $display("test modes done");
        wr(12'h008, 8'h01);
        repeat (4) @(posedge core_clk);
        chk({15'h0000, laneOe}, 16'h0000);
        wr(12'h008, 8'h00);
        $display("test lanes done");
        repeat (4) @(posedge core_clk);
        complete_run();
    end
endmodule
`default_nettype wire
